// ### bench/pmi_regs_checker.sv
// Purpose: Port-level assertions for the PHY indirect access registers
// Assumes: Single clock; only the top module ports are visible
// Notes:   Control state is hidden, so half the checks key on the line
`timescale 1ns/1ps
module pmi_regs_checker #(
  parameter int MMD_DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  pmi_pkg::pmi_bus_req_t busReq,
  input  wire logic [15:0]      regRdata,
  input  pmi_pkg::pmi_line_t    line,
  input  wire logic [15:0]      phyStatus,
  input  wire logic             mdixSel,
  input  wire logic             carrierSense,
  input  wire logic             heartbeatTestOn,
  input  wire logic             rxPolInvert,
  input  wire logic             jabberDetectOn
);
  import pmi_pkg::*;
  // ------------------------------------------------------------
  // Clocking and steps of a control access
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  logic armed_q;
  // Outputs still show reset values at the first edge after release,
  // so the checks start one edge later
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      armed_q <= 1'b0;
    end else begin
      armed_q <= 1'b1;
    end
  end
  default disable iff (!rst_n || !armed_q);
  sequence ctrlWr;
    busReq.wr && busReq.addr == OFS_PHY_CTRL;
  endsequence
  sequence ctrlRd;
    busReq.rd && busReq.addr == OFS_PHY_CTRL;
  endsequence
  // Read port answers only in the cycle after a read strobe
  AST_IDLE_ZERO: assert property (!busReq.rd |=> regRdata == 16'h0000)
    else $error("read data not zero outside read answer");
  AST_ACC_WO: assert property (
    busReq.rd && busReq.addr == OFS_ACCESS_CTRL |=> regRdata == 16'h0000)
    else $error("access control read not zero");
  AST_CTRL_RSV: assert property (ctrlRd |=> regRdata[15:7] == 9'h000)
    else $error("control reserved bits not zero");
  AST_CTRL_RB: assert property (
    ctrlWr ##1 !busReq.wr ##1 ctrlRd |=>
    regRdata[6:0] == $past(busReq.wdata[6:0], 3))
    else $error("control readback differs from write");
  AST_MDIX_FORCE: assert property (
    ctrlWr and busReq.wdata[6] == 1'b0 |->
    ##2 mdixSel == $past(busReq.wdata[5], 2))
    else $error("forced crossover not applied");
  AST_CRS_RX: assert property (line.rxActive |=> carrierSense)
    else $error("carrier sense missing on receive");
  AST_CRS_OFF: assert property (
    !line.rxActive && !line.txActive |=> !carrierSense)
    else $error("carrier sense without activity");
  AST_HB_FD: assert property (line.fullDuplex |=> !heartbeatTestOn)
    else $error("heartbeat test on in full duplex");
  AST_POL: assert property (
    !line.rxPolInverted || line.speed100 |=>
    rxPolInvert == $past(line.rxPolInverted))
    else $error("receive polarity wrong");
  AST_JAB_100: assert property (line.speed100 |=> !jabberDetectOn)
    else $error("jabber detection on at 100");
endmodule

bind pmi_regs pmi_regs_checker #(.MMD_DEPTH(MMD_DEPTH)) chk (
  .clk(clk), .rst_n(rst_n), .busReq(busReq), .regRdata(regRdata),
  .line(line), .phyStatus(phyStatus), .mdixSel(mdixSel),
  .carrierSense(carrierSense), .heartbeatTestOn(heartbeatTestOn),
  .rxPolInvert(rxPolInvert), .jabberDetectOn(jabberDetectOn));

// ### bench/pmi_station.sv
// Purpose: Station manager model driving the register port
// Assumes: Tasks are entered in the time step of a rising edge
// Notes:   An idle cycle follows each access so no strobe is set twice
`timescale 1ns/1ps
module pmi_station (
  input  wire logic             clk,
  output pmi_pkg::pmi_bus_req_t busReq,
  input  wire logic [15:0]      regRdata
);
  import pmi_pkg::*;
  // ------------------------------------------------------------
  // Bus cycles
  // ------------------------------------------------------------
  initial busReq = '0;
  // One write cycle, then one idle cycle
  task automatic busWrite(input logic [4:0] a, input logic [15:0] d);
    busReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    busReq <= '0;
    @(posedge clk);
  endtask
  // Answer is taken in the single cycle where it stands
  task automatic busRead(input logic [4:0] a, output logic [15:0] d);
    busReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk);
    busReq <= '0;
    #1 d = regRdata;
    @(posedge clk);
  endtask
  // Address function with device code, then the target location
  task automatic setAddr(input logic [4:0] dev, input logic [15:0] a);
    busWrite(OFS_ACCESS_CTRL, {11'h000, dev});
    busWrite(OFS_ADDR_DATA, a);
  endtask
  // Pick a function before using the window
  task automatic setFunc(input pmi_func_t fn, input logic [4:0] dev);
    busWrite(OFS_ACCESS_CTRL, {fn, 9'h000, dev});
  endtask
endmodule

// ### bench/tb_phy_mmd_indirect_and_control_regs.sv
// Purpose: Self-checking bench for the PHY indirect access registers
// Assumes: Device depth cut to 4 words to keep the run short
// Notes:   Line-side cases come from a row table; the rest by hand
`timescale 1ns/1ps
module tb_phy_mmd_indirect_and_control_regs;
  import pmi_pkg::*;
  typedef struct {
    logic [6:0] ctl;
    logic [5:0] ln;
    logic [4:0] exp;
  } pmi_row_t;
  logic          clk;
  logic          rst_n;
  pmi_bus_req_t  busReq;
  logic [15:0]   regRdata;
  logic [15:0]   phyStatus;
  logic [15:0]   rv;
  pmi_line_t     line;
  logic          mdixSel;
  logic          carrierSense;
  logic          heartbeatTestOn;
  logic          rxPolInvert;
  logic          jabberDetectOn;
  logic [4:0]    outs;
  logic [4:0]    d;
  int            err_count;
  int            checks_done;
  int            cycles;
  logic [4:0]    devs [3] = '{DEV_CODE_1, DEV_CODE_3, DEV_CODE_7};
  // Control bits, line {s100,fd,tx,rx,inv,auto}, {mdix,crs,hb,pol,jab}
  pmi_row_t      rows [5] = '{'{7'h0E, 6'b001011, 5'b01111},
                              '{7'h2E, 6'b011000, 5'b10001},
                              '{7'h51, 6'b111011, 5'b10010},
                              '{7'h69, 6'b111010, 5'b01010},
                              '{7'h60, 6'b001111, 5'b11001}};
  // ------------------------------------------------------------
  // Clock, instances and watchdog
  // ------------------------------------------------------------
  initial clk = 1'b0;
  always #12.5 clk = ~clk;
  pmi_regs #(.MMD_DEPTH(4)) DUT (
    .clk(clk), .rst_n(rst_n), .busReq(busReq), .regRdata(regRdata),
    .line(line), .phyStatus(phyStatus), .mdixSel(mdixSel),
    .carrierSense(carrierSense), .heartbeatTestOn(heartbeatTestOn),
    .rxPolInvert(rxPolInvert), .jabberDetectOn(jabberDetectOn));
  pmi_station mgr (.clk(clk), .busReq(busReq), .regRdata(regRdata));
  // Line-side outputs in the order of the table's expected field
  assign outs = {mdixSel, carrierSense, heartbeatTestOn, rxPolInvert,
                 jabberDetectOn};
  // Cuts a hang; the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      close_out();
    end
  end
  // ------------------------------------------------------------
  // Compare and report
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rdChk(input logic [4:0] a, input logic [15:0] exp,
                       input string nm);
    mgr.busRead(a, rv);
    chk(nm, rv, exp);
  endtask
  task automatic close_out();
    $display("Checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    line = '0;
    phyStatus = 16'h5A3C;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdChk(OFS_PHY_CTRL, 16'h0062, "ctrl_rst");
    rdChk(OFS_ADDR_DATA, ADDR_DATA_RST, "win_rst");
    rdChk(OFS_ACCESS_CTRL, 16'h0000, "acc_rd");
    rdChk(5'h12, 16'h0000, "unmapped");
    rdChk(OFS_PHY_STATUS, 16'h5A3C, "status");
    chk("jab_rst", {15'h0000, jabberDetectOn}, 16'h0001);
    $display("Test reset done");
    // Line table: set-only reserved bits must read back as zero
    foreach (rows[i]) begin
      line <= rows[i].ln;
      mgr.busWrite(OFS_PHY_CTRL, {9'h1FF, rows[i].ctl});
      rdChk(OFS_PHY_CTRL, {9'h000, rows[i].ctl}, "ctrl_rb");
      #1 chk("line_out", {11'h000, outs}, {11'h000, rows[i].exp});
      @(posedge clk);
    end
    $display("Test line table done");
    // Every function on every device, with distinct data per device
    foreach (devs[i]) begin
      d = devs[i];
      mgr.setAddr(d, 16'h0001);
      rdChk(OFS_ADDR_DATA, 16'h0001, "addr_rb");
      mgr.setFunc(FN_INC_RW, d);
      mgr.busWrite(OFS_ADDR_DATA, {11'h088, d});
      rdChk(OFS_ADDR_DATA, 16'h0000, "inc_rd");
      mgr.setFunc(FN_ADDR, d);
      rdChk(OFS_ADDR_DATA, 16'h0003, "inc_rw_addr");
      mgr.busWrite(OFS_ADDR_DATA, 16'h0001);
      mgr.setFunc(FN_INC_WR, d);
      rdChk(OFS_ADDR_DATA, {11'h088, d}, "incw_rd1");
      rdChk(OFS_ADDR_DATA, {11'h088, d}, "incw_rd2");
      mgr.busWrite(OFS_ADDR_DATA, {11'h110, d});
      mgr.setFunc(FN_ADDR, d);
      rdChk(OFS_ADDR_DATA, 16'h0002, "incw_addr");
      mgr.busWrite(OFS_ADDR_DATA, 16'h0001);
      mgr.setFunc(FN_DATA, d);
      rdChk(OFS_ADDR_DATA, {11'h110, d}, "data_rd1");
      rdChk(OFS_ADDR_DATA, {11'h110, d}, "data_rd2");
      mgr.setFunc(FN_ADDR, d);
      rdChk(OFS_ADDR_DATA, 16'h0001, "noinc_addr");
    end
    $display("Test indirect functions done");
    // Devices stay apart; an unknown code reaches nothing
    mgr.setAddr(5'h02, 16'h0003);
    rdChk(OFS_ADDR_DATA, 16'h0000, "bad_dev");
    mgr.setFunc(FN_ADDR, DEV_CODE_1);
    rdChk(OFS_ADDR_DATA, 16'h0001, "dev1_addr");
    mgr.setFunc(FN_DATA, DEV_CODE_1);
    rdChk(OFS_ADDR_DATA, 16'h2201, "dev1_data");
    rdChk(OFS_ACCESS_CTRL, 16'h0000, "acc_wo");
    $display("Test device isolation done");
    // Second reset in mid-run restores the defaults
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdChk(OFS_PHY_CTRL, 16'h0062, "ctrl_rst2");
    mgr.setFunc(FN_ADDR, DEV_CODE_1);
    rdChk(OFS_ADDR_DATA, ADDR_DATA_RST, "addr_rst2");
    $display("Test second reset done");
    close_out();
  end
endmodule

// ### hw/pmi_ctrl_fx.sv
// Purpose: Applies PHY control settings to the line-side signals
// Assumes: Line status comes from logic on the same clock
// Notes:   Every output is a flip-flop; effect lags inputs by one cycle
`timescale 1ns/1ps
module pmi_ctrl_fx (
  input  wire logic      clk,
  input  wire logic      rst_n,
  input  pmi_pkg::pmi_ctrl_t ctrl,
  input  pmi_pkg::pmi_line_t line,
  output logic           mdixSel,
  output logic           carrierSense,
  output logic           heartbeatTestOn,
  output logic           rxPolInvert,
  output logic           jabberDetectOn
);
  import pmi_pkg::*;

  logic crsOnTx;

  // Transmit counts only in 10 half duplex and in 100 modes
  assign crsOnTx = ctrl.carrierSenseOnTransmit
                 & (line.speed100 | ~line.fullDuplex);

  // Crossover; the reserved code behaves as automatic
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mdixSel <= 1'b0;
    end else begin
      case (ctrl.crossoverMode)
        XO_MDI:  mdixSel <= 1'b0;
        XO_MDIX: mdixSel <= 1'b1;
        default: mdixSel <= line.autoMdixSel;
      endcase
    end
  end

  // Carrier sense, heartbeat test, polarity and jabber gating
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      carrierSense    <= 1'b0;
      heartbeatTestOn <= 1'b0;
      rxPolInvert     <= 1'b0;
      jabberDetectOn  <= 1'b0;
    end else begin
      carrierSense    <= line.rxActive
                       | (line.txActive & crsOnTx);
      heartbeatTestOn <= ctrl.heartbeatTestEnable
                       & ~line.fullDuplex;
      rxPolInvert     <= line.rxPolInverted
                       & (ctrl.polarityReversalEnable
                          | line.speed100);
      jabberDetectOn  <= ~ctrl.jabberDetectDisable
                       & ~line.speed100;
    end
  end

endmodule

// ### hw/pmi_mmd_bank.sv
// Purpose: One manageable device: address register and data store
// Assumes: Only the low address bits select a stored word
// Notes:   Locations at or past DEPTH read zero and ignore writes
`timescale 1ns/1ps
module pmi_mmd_bank #(
  parameter int DEPTH = 32
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        addrWr,
  input  wire logic        dataWr,
  input  wire logic        incr,
  input  wire logic [15:0] wdata,
  output logic      [15:0] addrOut,
  output logic      [15:0] dataOut
);
  import pmi_pkg::*;

  localparam int IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [15:0] addr_q;
  logic [15:0] mem_q [DEPTH];
  logic        inRange;

  initial begin
    if (DEPTH < 2 || DEPTH > 65536)
      $error("pmi_mmd_bank: DEPTH out of range");
  end

  assign inRange = 32'(addr_q) < DEPTH;
  assign addrOut = addr_q;
  assign dataOut = inRange ? mem_q[addr_q[IW-1:0]] : 16'h0000;

  // Address register; increment lands before the next access
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_q <= ADDR_DATA_RST;
    end else if (addrWr) begin
      addr_q <= wdata;
    end else if (incr) begin
      addr_q <= addr_q + 16'h0001;
    end
  end

  // Data store at the location held in the address register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= 16'h0000;
      end
    end else if (dataWr && inRange) begin
      mem_q[addr_q[IW-1:0]] <= wdata;
    end
  end

endmodule

// ### hw/pmi_pkg.sv
// Purpose: Shared constants and types for the PHY indirect access block
// Assumes: 16-bit management registers on a 5-bit register index
// Notes:   Offsets, fields, reset values and codes are named only here
package pmi_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] OFS_ACCESS_CTRL = 5'h0D;
  localparam logic [4:0] OFS_ADDR_DATA   = 5'h0E;
  localparam logic [4:0] OFS_PHY_CTRL    = 5'h10;
  localparam logic [4:0] OFS_PHY_STATUS  = 5'h11;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FUNC_HI  = 15;
  localparam int FUNC_LO  = 14;
  localparam int DEV_HI   = 4;
  localparam int DEV_LO   = 0;
  localparam int XOVER_HI = 6;
  localparam int XOVER_LO = 5;
  localparam int RSV4_BIT = 4;
  localparam int CRS_BIT  = 3;
  localparam int SQE_BIT  = 2;
  localparam int POL_BIT  = 1;
  localparam int JAB_BIT  = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_DATA_RST = 16'h0000;
  localparam logic [1:0]  XOVER_RST     = 2'h3;
  localparam logic        POL_RST       = 1'h1;
  localparam logic        CRS_RST       = 1'h0;
  localparam logic        SQE_RST       = 1'h0;
  localparam logic        JAB_RST       = 1'h0;
  localparam logic        RSV4_RST      = 1'h0;

  // ----------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------
  localparam logic [4:0] DEV_CODE_1 = 5'h01;
  localparam logic [4:0] DEV_CODE_3 = 5'h03;
  localparam logic [4:0] DEV_CODE_7 = 5'h07;

  typedef enum logic [1:0] {
    FN_ADDR   = 2'h0,
    FN_DATA   = 2'h1,
    FN_INC_RW = 2'h2,
    FN_INC_WR = 2'h3
  } pmi_func_t;

  typedef enum logic [1:0] {
    XO_MDI  = 2'h0,
    XO_MDIX = 2'h1,
    XO_RSVD = 2'h2,
    XO_AUTO = 2'h3
  } pmi_xover_t;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } pmi_bus_req_t;

  typedef struct packed {
    logic speed100;
    logic fullDuplex;
    logic txActive;
    logic rxActive;
    logic rxPolInverted;
    logic autoMdixSel;
  } pmi_line_t;

  typedef struct packed {
    pmi_xover_t crossoverMode;
    logic       carrierSenseOnTransmit;
    logic       heartbeatTestEnable;
    logic       polarityReversalEnable;
    logic       jabberDetectDisable;
  } pmi_ctrl_t;

endpackage

// ### hw/pmi_regs.sv
// Purpose: PHY management registers for indirect device access and
//          PHY control, reached over a plain register port
// Assumes: Master keeps strobes one cycle long and never both at once
// Notes:   Read data stand for one cycle after the read strobe only
`timescale 1ns/1ps
module pmi_regs #(
  parameter int MMD_DEPTH = 32
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  pmi_pkg::pmi_bus_req_t busReq,
  output logic        [15:0] regRdata,
  input  pmi_pkg::pmi_line_t  line,
  input  wire logic   [15:0] phyStatus,
  output logic               mdixSel,
  output logic               carrierSense,
  output logic               heartbeatTestOn,
  output logic               rxPolInvert,
  output logic               jabberDetectOn
);
  import pmi_pkg::*;

  localparam int NDEV = 3;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  initial begin
    if (MMD_DEPTH < 2 || MMD_DEPTH > 65536)
      $error("pmi_regs: MMD_DEPTH out of range");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Maps a device code to a one-hot bank select; zero when unknown
  function automatic logic [NDEV-1:0] devSel(input logic [4:0] code);
    logic [NDEV-1:0] s;
    s = '0;
    if (code == DEV_CODE_1) begin
      s[0] = 1'b1;
    end else if (code == DEV_CODE_3) begin
      s[1] = 1'b1;
    end else if (code == DEV_CODE_7) begin
      s[2] = 1'b1;
    end
    return s;
  endfunction

  // True when the bus targets a given offset with a given strobe
  function automatic logic hit(input logic       strobe,
                               input logic [4:0] a,
                               input logic [4:0] ofs);
    return strobe && (a == ofs);
  endfunction

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic            acWr;
  logic            adWr;
  logic            adRd;
  logic            pcWr;
  logic            pcRd;
  logic            psRd;
  logic            acRd;

  assign acWr = hit(busReq.wr, busReq.addr, OFS_ACCESS_CTRL);
  assign acRd = hit(busReq.rd, busReq.addr, OFS_ACCESS_CTRL);
  assign adWr = hit(busReq.wr, busReq.addr, OFS_ADDR_DATA);
  assign adRd = hit(busReq.rd, busReq.addr, OFS_ADDR_DATA);
  assign pcWr = hit(busReq.wr, busReq.addr, OFS_PHY_CTRL);
  assign pcRd = hit(busReq.rd, busReq.addr, OFS_PHY_CTRL);
  assign psRd = hit(busReq.rd, busReq.addr, OFS_PHY_STATUS);

  // ----------------------------------------------------------------
  // Access control register
  // ----------------------------------------------------------------
  pmi_func_t       func_q;
  logic [4:0]      dev_q;

  // Function and device code are write-only; reserved bits drop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      func_q <= FN_ADDR;
      dev_q  <= 5'h00;
    end else if (acWr) begin
      func_q <= pmi_func_t'(busReq.wdata[FUNC_HI:FUNC_LO]);
      dev_q  <= busReq.wdata[DEV_HI:DEV_LO];
    end
  end

  // ----------------------------------------------------------------
  // Window steering
  // ----------------------------------------------------------------
  logic [NDEV-1:0] sel;
  logic            isAddr;
  logic            incOnRd;
  logic            incOnWr;
  logic            bump;
  logic [15:0]     bankAddr [NDEV];
  logic [15:0]     bankData [NDEV];

  assign sel     = devSel(dev_q);
  assign isAddr  = (func_q == FN_ADDR);
  assign incOnRd = (func_q == FN_INC_RW);
  assign incOnWr = (func_q == FN_INC_RW)
                 | (func_q == FN_INC_WR);

  // Post increment follows a data access in the same edge, so the
  // next window access already sees the new location
  assign bump = !isAddr
              && ((adWr && incOnWr) || (adRd && incOnRd));

  // ----------------------------------------------------------------
  // Device banks
  // ----------------------------------------------------------------
  // An unknown device code selects no bank: writes vanish and reads
  // return zero rather than aliasing onto a real device
  for (genvar g = 0; g < NDEV; g++) begin : gBank
    pmi_mmd_bank #(
      .DEPTH (MMD_DEPTH)
    ) uBank (
      .clk     (clk),
      .rst_n   (rst_n),
      .addrWr  (adWr && isAddr && sel[g]),
      .dataWr  (adWr && !isAddr && sel[g]),
      .incr    (bump && sel[g]),
      .wdata   (busReq.wdata),
      .addrOut (bankAddr[g]),
      .dataOut (bankData[g])
    );
  end

  // ----------------------------------------------------------------
  // Window read value
  // ----------------------------------------------------------------
  logic [15:0]     winVal;

  // Address or data view of the selected bank by current function
  always_comb begin
    winVal = ADDR_DATA_RST;
    for (int i = 0; i < NDEV; i++) begin
      if (sel[i]) begin
        winVal = isAddr ? bankAddr[i] : bankData[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // PHY control register
  // ----------------------------------------------------------------
  pmi_xover_t      xover_q;
  logic            rsv4_q;
  logic            crsTx_q;
  logic            sqe_q;
  logic            polRev_q;
  logic            jabDis_q;

  // Writable control bits; upper bits are not stored at all
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      xover_q  <= pmi_xover_t'(XOVER_RST);
      rsv4_q   <= RSV4_RST;
      crsTx_q  <= CRS_RST;
      sqe_q    <= SQE_RST;
      polRev_q <= POL_RST;
      jabDis_q <= JAB_RST;
    end else if (pcWr) begin
      xover_q  <= pmi_xover_t'(busReq.wdata[XOVER_HI:XOVER_LO]);
      rsv4_q   <= busReq.wdata[RSV4_BIT];
      crsTx_q  <= busReq.wdata[CRS_BIT];
      sqe_q    <= busReq.wdata[SQE_BIT];
      polRev_q <= busReq.wdata[POL_BIT];
      jabDis_q <= busReq.wdata[JAB_BIT];
    end
  end

  // Read view of the control register; bits 15:7 stay zero
  logic [15:0]     pcVal;

  always_comb begin
    pcVal                    = 16'h0000;
    pcVal[XOVER_HI:XOVER_LO] = xover_q;
    pcVal[RSV4_BIT]          = rsv4_q;
    pcVal[CRS_BIT]           = crsTx_q;
    pcVal[SQE_BIT]           = sqe_q;
    pcVal[POL_BIT]           = polRev_q;
    pcVal[JAB_BIT]           = jabDis_q;
  end

  // ----------------------------------------------------------------
  // Line-side effects
  // ----------------------------------------------------------------
  pmi_ctrl_t       ctrl;

  assign ctrl.crossoverMode          = xover_q;
  assign ctrl.carrierSenseOnTransmit = crsTx_q;
  assign ctrl.heartbeatTestEnable    = sqe_q;
  assign ctrl.polarityReversalEnable = polRev_q;
  assign ctrl.jabberDetectDisable    = jabDis_q;

  pmi_ctrl_fx uFx (
    .clk             (clk),
    .rst_n           (rst_n),
    .ctrl            (ctrl),
    .line            (line),
    .mdixSel         (mdixSel),
    .carrierSense    (carrierSense),
    .heartbeatTestOn (heartbeatTestOn),
    .rxPolInvert     (rxPolInvert),
    .jabberDetectOn  (jabberDetectOn)
  );

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Registered so data sit in exactly the cycle after the strobe;
  // write-only access control and unmapped offsets read zero. The
  // window value is sampled before any post increment lands.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdata <= 16'h0000;
    end else if (adRd) begin
      regRdata <= winVal;
    end else if (pcRd) begin
      regRdata <= pcVal;
    end else if (psRd) begin
      regRdata <= phyStatus;
    end else if (acRd) begin
      regRdata <= 16'h0000;
    end else begin
      regRdata <= 16'h0000;
    end
  end

endmodule
